// ==== shared/sdc_pkg.sv ====
// shared constants for the synthesizer divider configuration link and its two ends
package sdc_pkg;
  // ---------------------------------------------------------------
  // divider field layout
  // ---------------------------------------------------------------
  localparam int FB_INT_W = 11;
  localparam int FB_FRAC_W = 32;
  localparam int FB_W = FB_INT_W + FB_FRAC_W;
  localparam int HS_W = 11;
  localparam int LS_W = 3;
  localparam int LS_RATIO_W = 6;
  localparam int FRAME_BITS = FB_W + HS_W + LS_W;

  localparam logic [HS_W-1:0] HS_MIN = 11'h005;
  localparam logic [HS_W-1:0] HS_ODD_MAX = 11'h021;
  localparam logic [HS_W-1:0] HS_MAX = 11'h7FE;
  localparam logic [LS_W-1:0] LS_EXP_MAX = 3'h5;
  localparam logic [FB_W-1:0] FB_MIN = 43'h03C_0000_0000;
  localparam logic [FB_W-1:0] FB_MAX = 43'h7FD_FFFF_FFFF;

  // power-up setting of the device (156.75 MHz plan)
  localparam logic [FB_W-1:0] FB_RST = 43'h0C7_519C_F2BF;
  localparam logic [HS_W-1:0] HS_RST = 11'h046;
  localparam logic [LS_W-1:0] LS_RST = 3'h0;

  // ---------------------------------------------------------------
  // frequency plan limits, in Hz
  // ---------------------------------------------------------------
  localparam logic [31:0] FOSC_HZ = 32'h0347_FF10;
  localparam logic [35:0] VCO_MIN_HZ = 36'h2_83BA_EC00;
  localparam logic [35:0] VCO_MAX_A_HZ = 36'h2_EC0B_0E37;
  localparam logic [35:0] VCO_MAX_BC_HZ = 36'h2_D1CB_CA59;
  localparam logic [31:0] FOUT_MAX_A_HZ = 32'h5968_2F00;
  localparam logic [31:0] FOUT_MAX_B_HZ = 32'h2FAF_0800;
  localparam logic [31:0] FOUT_MAX_C_HZ = 32'h135F_1B40;
  localparam logic [1:0] GRADE_A = 2'h0;
  localparam logic [1:0] GRADE_B = 2'h1;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FOUT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_HS = 8'h0C;
  localparam logic [7:0] REG_LS = 8'h10;
  localparam logic [7:0] REG_FB_LO = 8'h14;
  localparam logic [7:0] REG_FB_HI = 8'h18;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_GRADE_LSB = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 32;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ==== shared/sdc_link_if.sv ====
// serial configuration link between divider host and oscillator device
`timescale 1ns/1ps
interface sdc_link_if;
  logic sclk;
  logic frame;
  logic data;
  modport host_mp (output sclk, output frame, output data);
  modport dev_mp (input sclk, input frame, input data);
endinterface

// ==== hw/sdc_device.sv ====
// oscillator device end: receives divider settings and divides the core clock
`timescale 1ns/1ps
module sdc_device (
  input wire logic clk_i,
  input wire logic rst_i,
  sdc_link_if.dev_mp link,
  output logic clk_out_o,
  output logic [sdc_pkg::FB_W-1:0] feedback_divider_o,
  output logic [sdc_pkg::HS_W-1:0] high_speed_out_divider_o,
  output logic [sdc_pkg::LS_RATIO_W-1:0] low_speed_ratio_o,
  output logic update_o
);
  import sdc_pkg::*;

  // ---------------------------------------------------------------
  // link synchroniser: {sclk, frame, data}
  // ---------------------------------------------------------------
  logic [2:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic sclk_d_r, sclk_d_nxt, frame_d_r, frame_d_nxt;
  logic [FRAME_BITS-1:0] shift_r, shift_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [FB_W-1:0] fb_r, fb_nxt;
  logic [HS_W-1:0] hs_r, hs_nxt;
  logic [LS_RATIO_W-1:0] ls_ratio_r, ls_ratio_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic upd_r, upd_nxt;
  logic [15:0] div_cnt_r, div_cnt_nxt;
  logic clk_out_r, clk_out_nxt;
  logic [LS_W-1:0] new_ls, ls_eff;
  logic [HS_W-1:0] new_hs, hs_eff;

  always_comb begin
    sync1_nxt = {link.sclk, link.frame, link.data};
    sync2_nxt = sync1_r;
    sclk_d_nxt = sync2_r[2];
    frame_d_nxt = sync2_r[1];
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    fb_nxt = fb_r;
    hs_nxt = hs_r;
    ls_ratio_nxt = ls_ratio_r;
    limit_nxt = limit_r;
    upd_nxt = 1'b0;
    new_hs = shift_r[LS_W +: HS_W];
    new_ls = shift_r[LS_W-1:0];
    // exponents 6 and 7 divide by 32 like 5
    ls_eff = (new_ls > LS_EXP_MAX) ? LS_EXP_MAX : new_ls;
    hs_eff = (new_hs == 11'h000) ? 11'h001 : new_hs;
    if (sync2_r[1] && !frame_d_r) begin
      cnt_nxt = 6'h00;
    end else if (sync2_r[1] && sync2_r[2] && !sclk_d_r) begin
      shift_nxt = {shift_r[FRAME_BITS-2:0], sync2_r[0]};
      if (cnt_r != 6'h3F) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
    // a frame of the wrong length leaves the old setting in place
    if (!sync2_r[1] && frame_d_r && cnt_r == 6'(FRAME_BITS)) begin
      fb_nxt = shift_r[FRAME_BITS-1 -: FB_W];
      hs_nxt = new_hs;
      ls_ratio_nxt = 6'h01 << ls_eff;
      limit_nxt = 16'(hs_eff) << ls_eff;
      upd_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sclk_d_r <= 1'b0;
      frame_d_r <= 1'b0;
      shift_r <= '0;
      cnt_r <= 6'h00;
      fb_r <= FB_RST;
      hs_r <= HS_RST;
      ls_ratio_r <= 6'h01;
      limit_r <= 16'(HS_RST);
      upd_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sclk_d_r <= sclk_d_nxt;
      frame_d_r <= frame_d_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      fb_r <= fb_nxt;
      hs_r <= hs_nxt;
      ls_ratio_r <= ls_ratio_nxt;
      limit_r <= limit_nxt;
      upd_r <= upd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output divider
  // ---------------------------------------------------------------
  // clk_i stands for half a core period, so toggling every hs*2^ls
  // cycles gives 50% duty for odd ratios too
  always_comb begin
    div_cnt_nxt = div_cnt_r + 16'h0001;
    clk_out_nxt = clk_out_r;
    if (div_cnt_r >= limit_r - 16'h0001) begin
      div_cnt_nxt = 16'h0000;
      clk_out_nxt = !clk_out_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= 16'h0000;
      clk_out_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      clk_out_r <= clk_out_nxt;
    end
  end

  // core frequency is xtal times this word
  assign feedback_divider_o = fb_r;
  assign high_speed_out_divider_o = hs_r;
  assign low_speed_ratio_o = ls_ratio_r;
  assign clk_out_o = clk_out_r;
  assign update_o = upd_r;
endmodule

// ==== hw/sdc_host.sv ====
// host end: plans divider settings for a wanted frequency and loads them
// ---------------------------------------------------------------
// Notes on behaviour
// - output equals core over hs times ls
// - core equals crystal times feedback divider
// - feedback divider is 11.32 unsigned fixed point
// - high-speed ratio is its 11-bit value
// - ratios 5..33 odd allowed, 50% duty
// - 34..2046 even only; 5..2046 overall
// - low-speed divides by two to exponent
// - exponents 6 and 7 divide by 32
// - feedback divider between 60.0 and 2045.99...
// - all divider fields unsigned, positive
// - crystal 55.05 MHz, core minimum 10.8 GHz
// - grade output ceilings; grade A core max
// - grades B, C core at most 12.1097 GHz
// - estimate total ratio from minimum core
// - choose smallest workable low-speed ratio
// - nearest legal high-speed ratio, core not below
// - core is output times ratio, range checked
// - fraction is floor of fraction times 2^32
// ---------------------------------------------------------------
`timescale 1ns/1ps
module sdc_host #(
  parameter int LINK_HALF = sdc_pkg::LINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sdc_link_if.host_mp link,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  import sdc_pkg::*;

  if (LINK_HALF < 1 || LINK_HALF > 255) begin : g_link_half_chk
    $error("LINK_HALF must lie in 1..255");
  end

  typedef enum {ST_IDLE, ST_START, ST_DIV_TOTAL, ST_PICK, ST_VCO, ST_DIV_FB, ST_SEND}
    sdc_state_type;

  sdc_state_type state_r, state_nxt;
  logic [31:0] fout_r, fout_nxt;
  logic [1:0] grade_r, grade_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt;
  logic [HS_W-1:0] hs_r, hs_nxt;
  logic [LS_W-1:0] ls_r, ls_nxt;
  logic [FB_W-1:0] fb_r, fb_nxt;
  logic [35:0] total_r, total_nxt;
  logic [71:0] num_r, num_nxt;
  logic [32:0] rem_r, rem_nxt;
  logic [31:0] den_r, den_nxt;
  logic [6:0] step_r, step_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sclk_r, sclk_nxt, frame_r, frame_nxt, data_r, data_nxt;
  logic [7:0] half_r, half_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic [FRAME_BITS-1:0] tx_r, tx_nxt;
  logic [32:0] rem_sh;
  logic qbit;
  logic [71:0] quot;
  logic [31:0] fout_max;
  logic [35:0] vco_max;
  logic [47:0] vco;
  logic pick_found;
  logic [LS_W-1:0] pick_exp;
  logic [35:0] pick_hs;
  logic [35:0] pick_tmp;
  logic [HS_W-1:0] hs_fix;

  // ---------------------------------------------------------------
  // grade limits and low-speed search
  // ---------------------------------------------------------------
  always_comb begin
    fout_max = FOUT_MAX_C_HZ;
    vco_max = VCO_MAX_BC_HZ;
    if (grade_r == GRADE_A) begin
      fout_max = FOUT_MAX_A_HZ;
      vco_max = VCO_MAX_A_HZ;
    end else if (grade_r == GRADE_B) begin
      fout_max = FOUT_MAX_B_HZ;
    end
  end

  always_comb begin
    pick_found = 1'b0;
    pick_exp = 3'h0;
    pick_hs = 36'h0_0000_0000;
    pick_tmp = 36'h0_0000_0000;
    for (int e = 0; e <= int'(LS_EXP_MAX); e++) begin
      // ceiling of total over 2^e
      pick_tmp = (total_r + ((36'h0_0000_0001 << e) - 36'h0_0000_0001)) >> e;
      if (!pick_found && pick_tmp <= 36'(HS_MAX)) begin
        pick_found = 1'b1;
        pick_exp = 3'(e);
        pick_hs = pick_tmp;
      end
    end
    hs_fix = pick_hs[HS_W-1:0];
    if (hs_fix < HS_MIN) begin
      hs_fix = HS_MIN;
    end else if (hs_fix > HS_ODD_MAX && hs_fix[0]) begin
      // rounding up keeps the core at or above its minimum
      hs_fix = hs_fix + 11'h001;
    end
  end

  assign rem_sh = {rem_r[31:0], num_r[71]};
  assign qbit = (rem_sh >= {1'b0, den_r});
  assign quot = {num_r[70:0], qbit};
  assign vco = (48'(fout_r) * 48'(hs_r)) << ls_r;

  // ---------------------------------------------------------------
  // sequencer, register port and link
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    fout_nxt = fout_r;
    grade_nxt = grade_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    err_nxt = err_r;
    hs_nxt = hs_r;
    ls_nxt = ls_r;
    fb_nxt = fb_r;
    total_nxt = total_r;
    num_nxt = num_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    step_nxt = step_r;
    sclk_nxt = sclk_r;
    frame_nxt = frame_r;
    data_nxt = data_r;
    half_nxt = half_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rdata_nxt = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        REG_CTRL: rdata_nxt = {29'h0000_0000, grade_r, 1'b0};
        REG_FOUT: rdata_nxt = fout_r;
        REG_STATUS: rdata_nxt = {29'h0000_0000, err_r, done_r, busy_r};
        REG_HS: rdata_nxt = {21'h00_0000, hs_r};
        REG_LS: rdata_nxt = {29'h0000_0000, ls_r};
        REG_FB_LO: rdata_nxt = fb_r[31:0];
        REG_FB_HI: rdata_nxt = {21'h00_0000, fb_r[FB_W-1:32]};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    // settings are frozen while a plan is running
    if (wr_i && !busy_r) begin
      if (addr_i == REG_FOUT) begin
        fout_nxt = wdata_i;
      end else if (addr_i == REG_CTRL) begin
        grade_nxt = wdata_i[CTRL_GRADE_LSB +: 2];
        if (wdata_i[CTRL_GO_BIT]) begin
          busy_nxt = 1'b1;
          done_nxt = 1'b0;
          err_nxt = 1'b0;
          state_nxt = ST_START;
        end
      end
    end
    case (state_r)
      ST_IDLE: begin
      end
      ST_START: begin
        if (fout_r == 32'h0000_0000 || fout_r > fout_max) begin
          state_nxt = ST_IDLE;
          busy_nxt = 1'b0;
          err_nxt = 1'b1;
        end else begin
          // ceiling of core minimum over wanted output
          num_nxt = {36'h0_0000_0000, VCO_MIN_HZ + 36'(fout_r) - 36'h0_0000_0001};
          rem_nxt = 33'h0_0000_0000;
          den_nxt = fout_r;
          step_nxt = 7'h00;
          state_nxt = ST_DIV_TOTAL;
        end
      end
      ST_DIV_TOTAL, ST_DIV_FB: begin
        rem_nxt = qbit ? (rem_sh - {1'b0, den_r}) : rem_sh;
        num_nxt = quot;
        step_nxt = step_r + 7'h01;
        if (step_r == 7'h47) begin
          if (state_r == ST_DIV_TOTAL) begin
            total_nxt = quot[35:0];
            state_nxt = ST_PICK;
          end else if (quot[71:FB_W] == '0 && quot[FB_W-1:0] >= FB_MIN
                       && quot[FB_W-1:0] <= FB_MAX) begin
            // truncated quotient keeps only the integer part of frac*2^32
            fb_nxt = quot[FB_W-1:0];
            tx_nxt = {quot[FB_W-1:0], hs_r, ls_r};
            data_nxt = quot[FB_W-1];
            frame_nxt = 1'b1;
            sclk_nxt = 1'b0;
            half_nxt = 8'h00;
            bit_nxt = 6'h00;
            state_nxt = ST_SEND;
          end else begin
            state_nxt = ST_IDLE;
            busy_nxt = 1'b0;
            err_nxt = 1'b1;
          end
        end
      end
      ST_PICK: begin
        if (!pick_found) begin
          state_nxt = ST_IDLE;
          busy_nxt = 1'b0;
          err_nxt = 1'b1;
        end else begin
          hs_nxt = hs_fix;
          ls_nxt = pick_exp;
          state_nxt = ST_VCO;
        end
      end
      ST_VCO: begin
        if (vco < 48'(VCO_MIN_HZ) || vco > 48'(vco_max)) begin
          state_nxt = ST_IDLE;
          busy_nxt = 1'b0;
          err_nxt = 1'b1;
        end else begin
          // core over crystal, scaled by 2^32 for the 11.32 layout
          num_nxt = {vco[39:0], 32'h0000_0000};
          rem_nxt = 33'h0_0000_0000;
          den_nxt = FOSC_HZ;
          step_nxt = 7'h00;
          state_nxt = ST_DIV_FB;
        end
      end
      ST_SEND: begin
        half_nxt = half_r + 8'h01;
        if (half_r == 8'(LINK_HALF - 1)) begin
          half_nxt = 8'h00;
          sclk_nxt = !sclk_r;
          // data moves on the falling edge, device samples on the rising one
          if (sclk_r) begin
            if (bit_r == 6'(FRAME_BITS - 1)) begin
              frame_nxt = 1'b0;
              data_nxt = 1'b0;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
              state_nxt = ST_IDLE;
            end else begin
              bit_nxt = bit_r + 6'h01;
              tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
              data_nxt = tx_r[FRAME_BITS-2];
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      fout_r <= 32'h0000_0000;
      grade_r <= GRADE_A;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      hs_r <= HS_RST;
      ls_r <= LS_RST;
      fb_r <= FB_RST;
      total_r <= 36'h0_0000_0000;
      num_r <= '0;
      rem_r <= 33'h0_0000_0000;
      den_r <= 32'h0000_0001;
      step_r <= 7'h00;
      rdata_r <= 32'h0000_0000;
      sclk_r <= 1'b0;
      frame_r <= 1'b0;
      data_r <= 1'b0;
      half_r <= 8'h00;
      bit_r <= 6'h00;
      tx_r <= '0;
    end else begin
      state_r <= state_nxt;
      fout_r <= fout_nxt;
      grade_r <= grade_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
      fb_r <= fb_nxt;
      total_r <= total_nxt;
      num_r <= num_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      step_r <= step_nxt;
      rdata_r <= rdata_nxt;
      sclk_r <= sclk_nxt;
      frame_r <= frame_nxt;
      data_r <= data_nxt;
      half_r <= half_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign link.sclk = sclk_r;
  assign link.frame = frame_r;
  assign link.data = data_r;
endmodule

// ==== sim/sdc_asserts.sv ====
// link framing, field loading and output divide checks
`timescale 1ns/1ps
module sdc_asserts #(
  parameter int LINK_HALF = sdc_pkg::LINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic frame,
  input wire logic data,
  input wire logic clk_out_o,
  input wire logic [sdc_pkg::FB_W-1:0] feedback_divider_o,
  input wire logic [sdc_pkg::HS_W-1:0] high_speed_out_divider_o,
  input wire logic [sdc_pkg::LS_RATIO_W-1:0] low_speed_ratio_o,
  input wire logic update_o
);
  import sdc_pkg::*;
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic sclk_q_r, frame_q_r, out_q_r, fresh_r, fresh_nxt, rise;
  logic [8:0] half_r, half_nxt;
  logic [6:0] bits_r, bits_nxt;
  logic [FRAME_BITS-1:0] sh_r, sh_nxt;
  logic [16:0] tog_r, tog_nxt, per, per_q_r;
  logic [5:0] sh_ratio;
  logic [HS_W-1:0] sh_hs;
  logic [FB_W-1:0] sh_fb;
  always_comb begin
    rise = sclk && !sclk_q_r && frame;
    half_nxt = (sclk != sclk_q_r || (frame && !frame_q_r)) ? 9'h001 :
      (half_r == 9'h1FF) ? half_r : half_r + 9'h001;
    bits_nxt = (frame && !frame_q_r) ? 7'h00 : bits_r + 7'(rise);
    sh_nxt = rise ? {sh_r[FRAME_BITS-2:0], data} : sh_r;
    tog_nxt = (clk_out_o != out_q_r) ? 17'h0_0001 :
      (tog_r == 17'h1_FFFF) ? tog_r : tog_r + 17'h0_0001;
    // first half period after a reload mixes old and new ratios
    fresh_nxt = update_o ? 1'b1 : (clk_out_o != out_q_r) ? 1'b0 : fresh_r;
    per = 17'(high_speed_out_divider_o) * 17'(low_speed_ratio_o);
    sh_ratio = (sh_r[2:0] > LS_EXP_MAX) ? 6'h20 : 6'h01 << sh_r[2:0];
    sh_hs = sh_r[13:3];
    sh_fb = sh_r[FRAME_BITS-1:14];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q_r <= 1'b0;
      frame_q_r <= 1'b0;
      out_q_r <= 1'b0;
      fresh_r <= 1'b1;
      half_r <= 9'h001;
      bits_r <= 7'h00;
      sh_r <= '0;
      tog_r <= 17'h0_0001;
      per_q_r <= 17'(HS_RST);
    end else begin
      sclk_q_r <= sclk;
      frame_q_r <= frame;
      out_q_r <= clk_out_o;
      fresh_r <= fresh_nxt;
      half_r <= half_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      tog_r <= tog_nxt;
      // ratio of the half period just ended; a toggle seen with the reload
      // pulse still belongs to the old setting
      per_q_r <= per;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_sclk_idle_low: assert property (!frame |-> !sclk)
    else $error("link clock high outside frame");
  a_frame_start: assert property ($rose(frame) |-> !sclk)
    else $error("frame opened with link clock high");
  a_data_idle: assert property (!frame |-> !data)
    else $error("data not idle outside frame");
  a_sclk_half: assert property ((sclk != sclk_q_r) |-> half_r == 9'(LINK_HALF))
    else $error("link clock half period wrong");
  a_frame_bits: assert property ($fell(frame) |-> bits_r == 7'(FRAME_BITS))
    else $error("frame bit count wrong");
  a_update_time: assert property ($fell(frame) |-> ##[1:10] update_o)
    else $error("no commit after frame");
  a_fields_load: assert property (update_o |-> ##[0:1] (feedback_divider_o == sh_fb
    && high_speed_out_divider_o == sh_hs && low_speed_ratio_o == sh_ratio))
    else $error("loaded dividers differ from frame");
  a_out_period: assert property ((clk_out_o != out_q_r) && !fresh_r |-> tog_r == per_q_r)
    else $error("output half period wrong");
  a_ratio_pow2: assert property ($onehot(low_speed_ratio_o))
    else $error("low speed ratio not a power of two");
  a_hs_legal: assert property ($fell(frame) |-> sh_hs >= HS_MIN && sh_hs <= HS_MAX
    && (sh_hs <= HS_ODD_MAX || !sh_hs[0]))
    else $error("high speed ratio illegal");
  a_fb_range: assert property ($fell(frame) |-> sh_fb >= FB_MIN && sh_fb <= FB_MAX)
    else $error("feedback divider out of range");
endmodule

// ==== sim/synth_divider_config_bench.sv ====
// self-checking bench: host plans dividers and loads the device
`timescale 1ns/1ps
module synth_divider_config_bench;
  import sdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, d;
  logic clk_out_o, update_o;
  logic [FB_W-1:0] fb_o, fb_exp = FB_RST;
  logic [HS_W-1:0] hs_o, hs_exp = HS_RST;
  logic [LS_RATIO_W-1:0] lsr_o;
  logic [LS_W-1:0] le_exp = LS_RST;
  int n_errors = 0;
  int compares = 0;
  int n_upd = 0;
  int cycles = 0;
  sdc_link_if u_sdc_link_if ();
  sdc_host #(.LINK_HALF(LINK_HALF_CYC)) u_sdc_host (.clk_i(clk_i), .rst_i(rst_i),
    .link(u_sdc_link_if.host_mp), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o));
  sdc_device u_sdc_device (.clk_i(clk_i), .rst_i(rst_i), .link(u_sdc_link_if.dev_mp),
    .clk_out_o(clk_out_o), .feedback_divider_o(fb_o), .high_speed_out_divider_o(hs_o),
    .low_speed_ratio_o(lsr_o), .update_o(update_o));
  sdc_asserts #(.LINK_HALF(LINK_HALF_CYC)) u_sdc_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(u_sdc_link_if.sclk), .frame(u_sdc_link_if.frame), .data(u_sdc_link_if.data),
    .clk_out_o(clk_out_o), .feedback_divider_o(fb_o), .high_speed_out_divider_o(hs_o),
    .low_speed_ratio_o(lsr_o), .update_o(update_o));
  initial begin
    forever begin
      #2 clk_i = ~clk_i;
    end
  end
  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (update_o === 1'b1) n_upd <= n_upd + 1;
    if (cycles == 95000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  function automatic logic [5:0] lsr(input logic [2:0] e);
    return (e > LS_EXP_MAX) ? 6'h20 : 6'h01 << e;
  endfunction
  function automatic void plan(input longint unsigned f, input logic [1:0] g, output bit ok,
    output logic [HS_W-1:0] hs, output logic [LS_W-1:0] le, output logic [FB_W-1:0] fb);
    longint unsigned tot, h, vco, top;
    int e;
    top = (g == GRADE_A) ? FOUT_MAX_A_HZ : (g == GRADE_B) ? FOUT_MAX_B_HZ : FOUT_MAX_C_HZ;
    ok = (f != 0) && (f <= top);
    if (!ok) return;
    tot = (VCO_MIN_HZ + f - 1) / f;
    e = 0;
    while (e < 5 && ((tot + (64'h1 << e) - 1) >> e) > HS_MAX) e++;
    h = (tot + (64'h1 << e) - 1) >> e;
    if (h < HS_MIN) h = HS_MIN;
    if (h > HS_ODD_MAX && h[0]) h++;
    vco = (f * h) << e;
    ok = h <= HS_MAX && vco <= ((g == GRADE_A) ? VCO_MAX_A_HZ : VCO_MAX_BC_HZ);
    hs = h[10:0];
    le = e[2:0];
    fb = {11'(vco / FOSC_HZ), 32'(((vco % FOSC_HZ) << 32) / FOSC_HZ)};
  endfunction
  // registers and device outputs against the last accepted plan
  task automatic expect_all();
    rd(REG_HS);
    check(d, hs_exp);
    rd(REG_LS);
    check(d, le_exp);
    rd(REG_FB_LO);
    check(d, fb_exp[31:0]);
    rd(REG_FB_HI);
    check(d, fb_exp[42:32]);
    check(fb_o, fb_exp);
    check(hs_o, hs_exp);
    check(lsr_o, lsr(le_exp));
  endtask
  task automatic run(input string name, input logic [31:0] f, input logic [1:0] g,
    input bit poke);
    bit ok;
    logic [HS_W-1:0] hs;
    logic [LS_W-1:0] le;
    logic [FB_W-1:0] fb;
    int u0;
    plan(f, g, ok, hs, le, fb);
    u0 = n_upd;
    wr(REG_FOUT, f);
    wr(REG_CTRL, {29'h0, g, 1'b1});
    // writes while busy must be dropped
    if (poke) wr(REG_FOUT, 32'h0000_0001);
    if (poke) wr(REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 1000; i++) begin
      rd(REG_STATUS);
      if (i == 0 && ok) check(d[STAT_BUSY_BIT], 1'b1);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    check(d[2:0], ok ? 3'h2 : 3'h4);
    for (int i = 0; i < 40 && ok && n_upd == u0; i++) @(posedge clk_i);
    check(64'(n_upd - u0), 64'(ok));
    rd(REG_FOUT);
    check(d, f);
    rd(REG_CTRL);
    check(d, {29'h0000_0000, g, 1'b0});
    if (ok) begin
      hs_exp = hs;
      le_exp = le;
      fb_exp = fb;
    end
    expect_all();
    repeat (2 * int'(hs_exp) * int'(lsr(le_exp)) + 8) @(posedge clk_i);
    $display("test %s done", name);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(70));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS);
    check(d, 32'h0000_0000);
    expect_all();
    rd(8'hFC);
    check(d, 32'h0000_0000);
    $display("test reset done");
    run("plan_c", 32'h0957_D0B0, 2'h2, 1'b1);
    run("max_a", FOUT_MAX_A_HZ, GRADE_A, 1'b0);
    run("over_a", FOUT_MAX_A_HZ + 32'h1, GRADE_A, 1'b0);
    run("over_b", FOUT_MAX_B_HZ + 32'h1, GRADE_B, 1'b0);
    run("zero", 32'h0000_0000, 2'h3, 1'b0);
    run("too_low", 32'h0001_86A0, GRADE_A, 1'b0);
    run("odd_hs", 32'h3B9A_CA00, GRADE_A, 1'b0);
    run("ls_used", 32'h000F_4240, GRADE_B, 1'b0);
    for (int i = 0; i < 8; i++) begin
      run("random", 32'h0131_2D00 + $urandom % 32'h122D_EE40, 2'($urandom), 1'b0);
    end
    wrap_up();
  end
endmodule
